//--- pkg/dtc_pkg.sv
// package for the dual timer/counter: register map, field layout, types
package dtc_pkg;

   // register offsets
   localparam logic [7:0] OFF_CTRL = 8'h88;
   localparam logic [7:0] OFF_MODE = 8'h89;
   localparam logic [7:0] OFF_TL0  = 8'h8a;
   localparam logic [7:0] OFF_TL1  = 8'h8b;
   localparam logic [7:0] OFF_TH0  = 8'h8c;
   localparam logic [7:0] OFF_TH1  = 8'h8d;

   // timer_control fields
   localparam int BIT_TF1 = 7;
   localparam int BIT_TR1 = 6;
   localparam int BIT_TF0 = 5;
   localparam int BIT_TR0 = 4;

   // timer_mode fields
   localparam int BIT_GATE   = 3;
   localparam int BIT_CT     = 2;
   localparam int BIT_M_HI   = 1;
   localparam int BIT_M_LO   = 0;

   // reset values
   localparam logic [7:0] RST_CTRL  = 8'h00;
   localparam logic [7:0] RST_MODE  = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;

   // timing: one machine cycle is twelve system clocks
   localparam int         CLK_PERIOD_NS = 100;
   localparam int         MC_CLKS       = 12;
   localparam logic [3:0] MC_LAST       = 4'(MC_CLKS - 1);

   // count limits
   localparam logic [4:0] PRE_MAX  = 5'h1f;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   typedef enum logic [1:0] {
      DTC_M13    = 2'b00,
      DTC_M16    = 2'b01,
      DTC_M8R    = 2'b10,
      DTC_MSPLIT = 2'b11
   } dtc_mode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtc_bus_req_t;

endpackage : dtc_pkg

//--- hw/dtc_cycle_gen.sv
// machine-cycle divider, pin synchronisers and count-pin edge detector
`timescale 1ns/1ps
module dtc_cycle_gen (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic count_input_pin,
   input  wire logic ext_interrupt_zero_pin,
   output logic      mc_tick,
   output logic      cnt_evt,
   output logic      gate_lvl
);

   logic [3:0] div_r,    div_nxt;
   logic [1:0] cin_sy_r, cin_sy_nxt;
   logic [1:0] int_sy_r, int_sy_nxt;
   logic       samp_r,   samp_nxt;
   logic       det_r,    det_nxt;
   logic       tick_r,   tick_nxt;
   logic       evt_r,    evt_nxt;

   always_comb begin
      cin_sy_nxt = {cin_sy_r[0], count_input_pin};
      int_sy_nxt = {int_sy_r[0], ext_interrupt_zero_pin};
      tick_nxt   = (div_r == dtc_pkg::MC_LAST);
      div_nxt    = tick_nxt ? 4'h0 : div_r + 4'h1; // R1
      samp_nxt   = samp_r;
      det_nxt    = det_r;
      evt_nxt    = 1'b0;
      if (tick_nxt) begin
         // one sample per machine cycle, so the fastest count is clock/24
         samp_nxt = cin_sy_r[1]; // R2
         det_nxt  = samp_r & ~cin_sy_r[1]; // R2
         evt_nxt  = det_r; // R3
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_r    <= 4'h0;
         cin_sy_r <= 2'h0;
         int_sy_r <= 2'h0;
         samp_r   <= 1'b0;
         det_r    <= 1'b0;
         tick_r   <= 1'b0;
         evt_r    <= 1'b0;
      end else begin
         div_r    <= div_nxt;
         cin_sy_r <= cin_sy_nxt;
         int_sy_r <= int_sy_nxt;
         samp_r   <= samp_nxt;
         det_r    <= det_nxt;
         tick_r   <= tick_nxt;
         evt_r    <= evt_nxt;
      end
   end

   assign mc_tick  = tick_r;
   assign cnt_evt  = evt_r;
   assign gate_lvl = int_sy_r[1];

endmodule : dtc_cycle_gen

//--- hw/dtc_top.sv
// dual timer/counter with register port, top level
// Summary of operation
// R1: each unit's timer function counts once per machine cycle, system clock divided by twelve.
// R2: counter function samples count pin each machine cycle; high then low is an edge.
// R3: a detected pin edge counts in the machine cycle after detection.
// R4: mode bit 2 selects unit 0 timer (0) or pin counter (1).
// R5: unit 0 counts only when run bit set and gate off or interrupt pin high.
// R6: unit 0 mode bits pick 13-bit, 16-bit, 8-bit reload or split bytes.
// R7: mode 0 uses high byte and low five bits; carry from bit 4.
// R8: mode 0 wrap from 1fff to zero sets unit 0 overflow flag.
// R9: mode 1 wrap from ffff to zero sets unit 0 overflow flag.
// R10: mode 2 low byte overflow sets flag and reloads from unchanged high byte.
// R11: mode 3 low byte is unit 0's own 8-bit counter with its controls.
// R12: mode 3 high byte times machine cycles under unit 1 run and flag.
// R13: unit 1 is only a clock/12 timer in 8-bit reload mode.
// R14: unit 1 overflow sets its flag and reloads low byte from high byte.
// R15: overflow flags are set by hardware and stay until software clears.
// R16: control bits 7..4 hold unit1 flag, unit1 run, unit0 flag, unit0 run.
// R17: software writes load a count byte at once; reads give live count.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dtc_top (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire dtc_pkg::dtc_bus_req_t bus_req,
   input  wire logic                  count_input_pin,
   input  wire logic                  ext_interrupt_zero_pin,
   output logic [7:0]                 rd_data,
   output logic                       unit0_overflow_flag,
   output logic                       unit1_overflow_flag,
   output logic                       unit1_ovf_pulse
);

   logic                  mc_tick;
   logic                  cnt_evt;
   logic                  gate_lvl;
   logic [7:0]            tl0_r, tl0_nxt;
   logic [7:0]            th0_r, th0_nxt;
   logic [7:0]            tl1_r, tl1_nxt;
   logic [7:0]            th1_r, th1_nxt;
   logic [7:0]            mode_r, mode_nxt;
   logic                  tf0_r, tf0_nxt;
   logic                  tf1_r, tf1_nxt;
   logic                  tr0_r, tr0_nxt;
   logic                  tr1_r, tr1_nxt;
   logic [7:0]            rd_r, rd_nxt;
   logic                  pls_r, pls_nxt;
   logic                  en0;
   logic                  inc0;
   logic                  inc0h;
   logic                  inc1;
   logic                  ovf0;
   logic                  ovf1;
   logic [4:0]            pre;
   dtc_pkg::dtc_mode_t    md;

   dtc_cycle_gen u_gen (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .count_input_pin        (count_input_pin),
      .ext_interrupt_zero_pin (ext_interrupt_zero_pin),
      .mc_tick                (mc_tick),
      .cnt_evt                (cnt_evt),
      .gate_lvl               (gate_lvl)
   );

   function automatic logic hit(input dtc_pkg::dtc_bus_req_t q, input logic [7:0] off);
      hit = q.wr && (q.addr == off);
   endfunction : hit

   always_comb begin
      md    = dtc_pkg::dtc_mode_t'(mode_r[dtc_pkg::BIT_M_HI:dtc_pkg::BIT_M_LO]); // R6
      en0   = tr0_r && (!mode_r[dtc_pkg::BIT_GATE] || gate_lvl); // R5
      inc0  = en0 && (mode_r[dtc_pkg::BIT_CT] ? cnt_evt : mc_tick); // R4 R11
      inc0h = (md == dtc_pkg::DTC_MSPLIT) && tr1_r && mc_tick; // R12
      // unit 1 loses its run bit to the split high byte, so it halts in mode 3
      inc1  = (md != dtc_pkg::DTC_MSPLIT) && tr1_r && mc_tick; // R13
   end

   always_comb begin
      tl0_nxt  = tl0_r;
      th0_nxt  = th0_r;
      tl1_nxt  = tl1_r;
      th1_nxt  = th1_r;
      mode_nxt = mode_r;
      tf0_nxt  = tf0_r;
      tf1_nxt  = tf1_r;
      tr0_nxt  = tr0_r;
      tr1_nxt  = tr1_r;
      ovf0     = 1'b0;
      ovf1     = 1'b0;
      pre      = tl0_r[4:0] + 5'h01;
      if (inc0) begin
         unique case (md)
            dtc_pkg::DTC_M13: begin
               // upper three low-byte bits are left alone
               tl0_nxt = {tl0_r[7:5], pre}; // R7
               if (tl0_r[4:0] == dtc_pkg::PRE_MAX) begin
                  th0_nxt = th0_r + 8'h01; // R7
                  ovf0    = (th0_r == dtc_pkg::BYTE_MAX); // R8
               end
            end
            dtc_pkg::DTC_M16: begin
               {th0_nxt, tl0_nxt} = {th0_r, tl0_r} + 16'h0001; // R9
               ovf0 = (tl0_r == dtc_pkg::BYTE_MAX) && (th0_r == dtc_pkg::BYTE_MAX); // R9
            end
            dtc_pkg::DTC_M8R: begin
               if (tl0_r == dtc_pkg::BYTE_MAX) begin
                  tl0_nxt = th0_r; // R10
                  ovf0    = 1'b1; // R10
               end else begin
                  tl0_nxt = tl0_r + 8'h01;
               end
            end
            dtc_pkg::DTC_MSPLIT: begin
               tl0_nxt = tl0_r + 8'h01; // R11
               ovf0    = (tl0_r == dtc_pkg::BYTE_MAX); // R11
            end
         endcase
      end
      if (inc0h) begin
         th0_nxt = th0_r + 8'h01; // R12
         ovf1    = (th0_r == dtc_pkg::BYTE_MAX); // R12
      end
      if (inc1) begin
         if (tl1_r == dtc_pkg::BYTE_MAX) begin
            tl1_nxt = th1_r; // R14
            ovf1    = 1'b1; // R14
         end else begin
            tl1_nxt = tl1_r + 8'h01;
         end
      end
      // a software write to a byte beats the count in the same cycle
      if (hit(bus_req, dtc_pkg::OFF_TL0)) tl0_nxt = bus_req.wdata; // R17
      if (hit(bus_req, dtc_pkg::OFF_TH0)) th0_nxt = bus_req.wdata; // R17
      if (hit(bus_req, dtc_pkg::OFF_TL1)) tl1_nxt = bus_req.wdata; // R17
      if (hit(bus_req, dtc_pkg::OFF_TH1)) th1_nxt = bus_req.wdata; // R17
      if (hit(bus_req, dtc_pkg::OFF_MODE)) mode_nxt = bus_req.wdata;
      if (hit(bus_req, dtc_pkg::OFF_CTRL)) begin
         tf1_nxt = bus_req.wdata[dtc_pkg::BIT_TF1]; // R16
         tr1_nxt = bus_req.wdata[dtc_pkg::BIT_TR1]; // R16
         tf0_nxt = bus_req.wdata[dtc_pkg::BIT_TF0]; // R16
         tr0_nxt = bus_req.wdata[dtc_pkg::BIT_TR0]; // R16
      end
      // hardware set wins over a clear in the same cycle
      if (ovf0) tf0_nxt = 1'b1; // R15
      if (ovf1) tf1_nxt = 1'b1; // R15
      pls_nxt = ovf1;
   end

   always_comb begin
      rd_nxt = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            dtc_pkg::OFF_CTRL: rd_nxt = {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0}; // R16
            dtc_pkg::OFF_MODE: rd_nxt = mode_r;
            dtc_pkg::OFF_TL0:  rd_nxt = tl0_r; // R17
            dtc_pkg::OFF_TH0:  rd_nxt = th0_r; // R17
            dtc_pkg::OFF_TL1:  rd_nxt = tl1_r; // R17
            dtc_pkg::OFF_TH1:  rd_nxt = th1_r; // R17
            default:           rd_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tl0_r  <= dtc_pkg::RST_COUNT;
         th0_r  <= dtc_pkg::RST_COUNT;
         tl1_r  <= dtc_pkg::RST_COUNT;
         th1_r  <= dtc_pkg::RST_COUNT;
         mode_r <= dtc_pkg::RST_MODE;
         tf1_r  <= dtc_pkg::RST_CTRL[dtc_pkg::BIT_TF1];
         tr1_r  <= dtc_pkg::RST_CTRL[dtc_pkg::BIT_TR1];
         tf0_r  <= dtc_pkg::RST_CTRL[dtc_pkg::BIT_TF0];
         tr0_r  <= dtc_pkg::RST_CTRL[dtc_pkg::BIT_TR0];
         rd_r   <= 8'h00;
         pls_r  <= 1'b0;
      end else begin
         tl0_r  <= tl0_nxt;
         th0_r  <= th0_nxt;
         tl1_r  <= tl1_nxt;
         th1_r  <= th1_nxt;
         mode_r <= mode_nxt;
         tf1_r  <= tf1_nxt;
         tr1_r  <= tr1_nxt;
         tf0_r  <= tf0_nxt;
         tr0_r  <= tr0_nxt;
         rd_r   <= rd_nxt;
         pls_r  <= pls_nxt;
      end
   end

   assign rd_data             = rd_r;
   assign unit0_overflow_flag = tf0_r;
   assign unit1_overflow_flag = tf1_r;
   assign unit1_ovf_pulse     = pls_r;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic quiet0;
   logic quiet1;
   logic ctrl_wr;
   assign quiet0  = !hit(bus_req, dtc_pkg::OFF_TL0) && !hit(bus_req, dtc_pkg::OFF_TH0)
                    && !hit(bus_req, dtc_pkg::OFF_MODE);
   assign quiet1  = !hit(bus_req, dtc_pkg::OFF_TL1) && !hit(bus_req, dtc_pkg::OFF_TH1);
   assign ctrl_wr = hit(bus_req, dtc_pkg::OFF_CTRL);

   sequence s_gap11;
      !mc_tick [*8] ##1 !mc_tick [*3];
   endsequence

   sequence s_rd_tl0;
      bus_req.rd && (bus_req.addr == dtc_pkg::OFF_TL0);
   endsequence

   property p_tick_period;
      mc_tick |=> s_gap11 ##1 mc_tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("machine tick period wrong"); // R1

   property p_m16_inc;
      (md == dtc_pkg::DTC_M16) && en0 && !mode_r[dtc_pkg::BIT_CT] && mc_tick && quiet0
      |=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001;
   endproperty
   a_m16_inc: assert property (p_m16_inc) else $error("16-bit count did not step"); // R9

   property p_m16_wrap;
      (md == dtc_pkg::DTC_M16) && inc0 && quiet0 && ({th0_r, tl0_r} == 16'hffff)
      |=> tf0_r && ({th0_r, tl0_r} == 16'h0000) ##1 tf0_r;
   endproperty
   a_m16_wrap: assert property (p_m16_wrap) else $error("16-bit wrap missed flag"); // R9

   property p_m0_carry;
      (md == dtc_pkg::DTC_M13) && inc0 && quiet0 && (tl0_r[4:0] == 5'h1f)
      |=> (th0_r == $past(th0_r) + 8'h01) && (tl0_r[4:0] == 5'h00);
   endproperty
   a_m0_carry: assert property (p_m0_carry) else $error("13-bit carry wrong"); // R7

   property p_m2_reload;
      (md == dtc_pkg::DTC_M8R) && inc0 && quiet0 && (tl0_r == 8'hff)
      |=> (tl0_r == $past(th0_r)) && $stable(th0_r) && tf0_r;
   endproperty
   a_m2_reload: assert property (p_m2_reload) else $error("unit 0 reload wrong"); // R10

   property p_u1_reload;
      inc1 && quiet1 && (tl1_r == 8'hff) |=> (tl1_r == $past(th1_r)) && tf1_r && unit1_ovf_pulse;
   endproperty
   a_u1_reload: assert property (p_u1_reload) else $error("unit 1 reload wrong"); // R14

   property p_gate_hold;
      tr0_r && mode_r[dtc_pkg::BIT_GATE] && !gate_lvl && quiet0
      |=> $stable(tl0_r) && ($past(md) == dtc_pkg::DTC_MSPLIT || $stable(th0_r));
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gated unit 0 moved"); // R5

   property p_pin_count;
      mode_r[dtc_pkg::BIT_CT] && (md != dtc_pkg::DTC_MSPLIT) && en0 && !cnt_evt && quiet0
      |=> $stable({th0_r, tl0_r});
   endproperty
   a_pin_count: assert property (p_pin_count) else $error("counter moved without edge"); // R3

   property p_m3_high;
      (md == dtc_pkg::DTC_MSPLIT) && tr1_r && mc_tick && quiet0 && (th0_r != 8'hff)
      |=> (th0_r == $past(th0_r) + 8'h01) && $stable(tl1_r);
   endproperty
   a_m3_high: assert property (p_m3_high) else $error("split high byte wrong"); // R12

   property p_flag_sticky;
      tf0_r && !ctrl_wr |=> tf0_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself"); // R15

   property p_rd_tl0;
      s_rd_tl0 |=> rd_data == $past(tl0_r);
   endproperty
   a_rd_tl0: assert property (p_rd_tl0) else $error("read data wrong"); // R17

   property p_flag1_sticky;
      tf1_r && !ctrl_wr |=> tf1_r;
   endproperty
   a_flag1_sticky: assert property (p_flag1_sticky) else $error("unit 1 flag dropped"); // R15

   // a clear written in the overflow cycle must lose
   property p_set_wins;
      ovf0 |=> tf0_r;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("overflow lost to clear"); // R15

   property p_u1_halt;
      (md == dtc_pkg::DTC_MSPLIT) && quiet1 |=> $stable(tl1_r);
   endproperty
   a_u1_halt: assert property (p_u1_halt) else $error("unit 1 ran in split mode"); // R13

   property p_m3_low;
      (md == dtc_pkg::DTC_MSPLIT) && inc0 && quiet0 && (tl0_r == 8'hff)
      |=> (tl0_r == 8'h00) && tf0_r;
   endproperty
   a_m3_low: assert property (p_m3_low) else $error("split low byte wrap wrong"); // R11

   property p_rd_idle;
      !bus_req.rd |=> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle"); // R17

   property p_evt_on_tick;
      cnt_evt |-> mc_tick;
   endproperty
   a_evt_on_tick: assert property (p_evt_on_tick) else $error("pin count off tick"); // R2

endmodule : dtc_top

//--- dv/dtc_pin_model.sv
// far-side model: count pin pulse source and gate pin level
`timescale 1ns/1ps
module dtc_pin_model (
   input  wire logic       clk_sys,
   input  wire logic       pulse_on,
   input  wire logic [7:0] half_clks,
   input  wire logic       gate_hi,
   output logic            count_input_pin,
   output logic            ext_interrupt_zero_pin
);
   logic [7:0] cnt_r;

   initial begin
      count_input_pin = 1'b1;
      ext_interrupt_zero_pin = 1'b0;
      cnt_r = 8'h00;
   end

   // each level held half_clks clocks; the bench keeps it at 12 or more
   always @(posedge clk_sys) begin
      ext_interrupt_zero_pin <= gate_hi;
      if (!pulse_on) begin
         cnt_r <= 8'h00;
         count_input_pin <= 1'b1;
      end else if (cnt_r == half_clks - 8'h01) begin
         cnt_r <= 8'h00;
         count_input_pin <= ~count_input_pin;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule : dtc_pin_model

//--- dv/tb.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module tb;
   logic                  clk_sys = 1'b0;
   logic                  rst = 1'b1;
   dtc_pkg::dtc_bus_req_t bus_req = '0;
   logic                  count_input_pin;
   logic                  ext_interrupt_zero_pin;
   logic [7:0]            rd_data;
   logic                  unit0_overflow_flag;
   logic                  unit1_overflow_flag;
   logic                  unit1_ovf_pulse;
   logic                  pulse_on = 1'b0;
   logic                  gate_hi = 1'b0;
   logic [7:0]            d;
   logic [7:0]            r;
   int                    miscompares = 0;
   int                    n_compared = 0;
   time                   t1;
   time                   t2;

   always #50 clk_sys = ~clk_sys;

   dtc_top dtc_top_inst (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .bus_req                (bus_req),
      .count_input_pin        (count_input_pin),
      .ext_interrupt_zero_pin (ext_interrupt_zero_pin),
      .rd_data                (rd_data),
      .unit0_overflow_flag    (unit0_overflow_flag),
      .unit1_overflow_flag    (unit1_overflow_flag),
      .unit1_ovf_pulse        (unit1_ovf_pulse)
   );

   dtc_pin_model dtc_pin_model_inst (
      .clk_sys                (clk_sys),
      .pulse_on               (pulse_on),
      .half_clks              (8'h1e),
      .gate_hi                (gate_hi),
      .count_input_pin        (count_input_pin),
      .ext_interrupt_zero_pin (ext_interrupt_zero_pin)
   );

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle strobes, changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 v = rd_data;
   endtask : rd

   // polls each cycle; pulse output lasts one cycle so it is never missed
   task automatic wait_sig(input int which, input int limit, output time t);
      logic s;
      for (int i = 0; i < limit; i++) begin
         @(posedge clk_sys);
         #1 s = (which == 0) ? unit0_overflow_flag :
                (which == 1) ? unit1_overflow_flag : unit1_ovf_pulse;
         if (s === 1'b1) begin
            t = $time;
            return;
         end
      end
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      t = $time;
   endtask : wait_sig

   function automatic int reload_clks(input logic [7:0] rv, input int per_tick);
      return (256 - int'(rv)) * per_tick;
   endfunction : reload_clks

   // period between two flag sets or two unit 1 pulses; a flag is cleared by software in between
   task automatic period(input int which, input logic [7:0] ctl, input int exp);
      wait_sig(which, 8000, t1);
      if (which < 2) wr(dtc_pkg::OFF_CTRL, ctl);
      wait_sig(which, 8000, t2);
      chk(8'((t2 - t1) / 100 / 256), 8'(exp / 256));
      chk(8'((t2 - t1) / 100), 8'(exp));
   endtask : period

   initial begin
      // clean run is near 10k cycles; 30k leaves margin
      #3_000_000;
      miscompares++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h1a3ed99f));
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      for (int a = 8'h88; a <= 8'h8d; a++) begin
         rd(8'(a), d);
         chk(d, 8'h00);
      end
      rd(8'h80, d);
      chk(d, 8'h00);
      for (int a = 8'h89; a <= 8'h8d; a++) begin
         r = 8'($urandom);
         wr(8'(a), r);
         rd(8'(a), d);
         chk(d, r);
      end
      wr(dtc_pkg::OFF_CTRL, 8'h0f);
      rd(dtc_pkg::OFF_CTRL, d);
      chk(d, 8'h00);
      // unit 0 mode 2 timer: period and untouched reload byte
      r = 8'hc0 + 8'($urandom % 63);
      wr(dtc_pkg::OFF_MODE, 8'h02);
      wr(dtc_pkg::OFF_TH0, r);
      wr(dtc_pkg::OFF_TL0, r);
      wr(dtc_pkg::OFF_CTRL, 8'h10);
      period(0, 8'h10, reload_clks(r, dtc_pkg::MC_CLKS));
      rd(dtc_pkg::OFF_TH0, d);
      chk(d, r);
      // unit 1 reload timer
      r = 8'hc0 + 8'($urandom % 63);
      wr(dtc_pkg::OFF_TH1, r);
      wr(dtc_pkg::OFF_CTRL, 8'h40);
      period(2, 8'h40, reload_clks(r, dtc_pkg::MC_CLKS));
      chk({7'h0, unit1_overflow_flag}, 8'h01);
      rd(dtc_pkg::OFF_TH1, d);
      chk(d, r);
      // mode 1 wrap ffff to 0000
      wr(dtc_pkg::OFF_CTRL, 8'h00);
      wr(dtc_pkg::OFF_MODE, 8'h01);
      wr(dtc_pkg::OFF_TH0, 8'hff);
      wr(dtc_pkg::OFF_TL0, 8'hf0);
      wr(dtc_pkg::OFF_CTRL, 8'h10);
      wait_sig(0, 17 * dtc_pkg::MC_CLKS, t1);
      rd(dtc_pkg::OFF_TH0, d);
      chk(d, 8'h00);
      // mode 0 wrap 1fff to 0000, top three low bits left alone
      wr(dtc_pkg::OFF_CTRL, 8'h00);
      wr(dtc_pkg::OFF_MODE, 8'h00);
      wr(dtc_pkg::OFF_TH0, 8'hff);
      wr(dtc_pkg::OFF_TL0, 8'hfe);
      wr(dtc_pkg::OFF_CTRL, 8'h10);
      wait_sig(0, 3 * dtc_pkg::MC_CLKS, t1);
      rd(dtc_pkg::OFF_TH0, d);
      chk(d, 8'h00);
      rd(dtc_pkg::OFF_TL0, d);
      chk({5'h0, d[7:5]}, 8'h07);
      // mode 3: high byte times under unit 1 run bit
      wr(dtc_pkg::OFF_CTRL, 8'h00);
      wr(dtc_pkg::OFF_MODE, 8'h03);
      wr(dtc_pkg::OFF_TH0, 8'h00);
      wr(dtc_pkg::OFF_TL0, 8'hf0);
      wr(dtc_pkg::OFF_CTRL, 8'h50);
      period(2, 8'h50, reload_clks(8'h00, dtc_pkg::MC_CLKS));
      chk({7'h0, unit0_overflow_flag}, 8'h01);
      // counter function: one falling edge every sixty clocks
      wr(dtc_pkg::OFF_CTRL, 8'h00);
      wr(dtc_pkg::OFF_MODE, 8'h06);
      wr(dtc_pkg::OFF_TH0, 8'hfc);
      wr(dtc_pkg::OFF_TL0, 8'hfc);
      pulse_on <= 1'b1;
      wr(dtc_pkg::OFF_CTRL, 8'h10);
      period(0, 8'h10, reload_clks(8'hfc, 60));
      // gate qualify: held while pin low, runs once pin high
      wr(dtc_pkg::OFF_CTRL, 8'h00);
      pulse_on <= 1'b0;
      wr(dtc_pkg::OFF_MODE, 8'h0a);
      wr(dtc_pkg::OFF_TL0, 8'h00);
      wr(dtc_pkg::OFF_CTRL, 8'h10);
      repeat (60) @(posedge clk_sys);
      rd(dtc_pkg::OFF_TL0, d);
      chk(d, 8'h00);
      gate_hi <= 1'b1;
      repeat (60) @(posedge clk_sys);
      rd(dtc_pkg::OFF_TL0, d);
      chk({7'h0, d != 8'h00}, 8'h01);
      // reset in mid-run while unit 0 is counting
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      for (int a = 8'h88; a <= 8'h8d; a++) begin
         rd(8'(a), d);
         chk(d, 8'h00);
      end
      chk({6'h0, unit1_overflow_flag, unit0_overflow_flag}, 8'h00);
      print_verdict();
   end
endmodule : tb
